// *** src/sttl_supervisor.sv ***
// Stop, travel-limit, pulse-store and torque/velocity limit supervisor.
// Assumes a host driving modes and commands on clk_sys; stop, limit,
// pulse and enable lines arrive as asynchronous pins.
`include "sttl_defines.svh"

module sttl_supervisor #(
  parameter int TICK_CYCLES = `STTL_TICK_CYCLES,
  parameter int DIS_CYCLES  = `STTL_DIS_CYCLES
) (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   resetn,
  // Mode and commands from the host
  input  wire sttl_pkg::sttl_mode_t   mode_sel,
  input  wire sttl_pkg::sttl_scale_t  scale,
  input  wire sttl_pkg::sttl_caps_t   caps,
  input  wire logic                   cap_always_on,
  input  wire logic                   cap_enable_in,
  input  wire logic signed [23:0]     velocity_cmd_in,
  input  wire logic signed [15:0]     loop_torque_demand,
  input  wire logic        [19:0]     motor_max_speed,
  input  wire logic        [22:0]     stop_decel_step,
  input  wire logic        [22:0]     limit_decel_step,
  // Asynchronous pins
  input  wire logic [`STTL_PIN_COUNT-1:0] pins_in,
  // Loop control
  output logic                        pos_loop_en,
  output logic                        vel_loop_en,
  output logic                        torque_loop_en,
  // Commands to the loops
  output logic signed [23:0]          vel_ref,
  output logic signed [15:0]          torque_req,
  output logic signed [15:0]          torque_act,
  output logic signed [31:0]          position_cmd,
  // Status
  output logic                        torque_limit_active,
  output logic                        stop_active,
  output logic                        limit_fault,
  output logic                        limit_indicate,
  output logic signed [31:0]          stored_pulses
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [`STTL_PIN_COUNT-1:0] sync1, sync2, sync3, pin_q, pin_d;
  logic [15:0]         tick_cnt;
  logic                tick;
  logic [19:0]         dis_cnt;
  logic                dis_clear;
  logic                stop_pin, lim_pos, lim_neg, lim_any, stopping;
  logic                pls_up, pls_dn, tq_mode, pulse_mode;
  logic [23:0]         vmax;
  logic signed [23:0]  cmd_c, next_vel, stepped;
  logic signed [15:0]  scaled_tq, sel_tq, next_act;
  logic [14:0]         total_cap;
  logic                tq_blocked;
  logic                clear_store;

  localparam logic signed [31:0] STORE_MAX = 32'sh7fffffff;
  localparam logic signed [31:0] STORE_MIN = 32'sh80000000;

  function automatic logic signed [23:0] toward_zero(
    input logic signed [23:0] v, input logic [22:0] step);
    logic signed [23:0] s;
    s = $signed({1'b0, step});
    if (v > s) begin
      toward_zero = v - s;
    end else if (v < -s) begin
      toward_zero = v + s;
    end else begin
      toward_zero = '0;
    end
  endfunction : toward_zero

  function automatic logic [16:0] mag16(input logic signed [15:0] v);
    mag16 = v[15] ? 17'(-17'(v)) : 17'(v);
  endfunction : mag16

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Third stage filters: a level counts once stages two and three agree
  for (genvar i = 0; i < `STTL_PIN_COUNT; i++) begin : g_sync
    always_ff @(posedge clk_sys) begin
      if (!resetn) begin
        sync1[i] <= 1'b0;
        sync2[i] <= 1'b0;
        sync3[i] <= 1'b0;
        pin_q[i] <= 1'b0;
        pin_d[i] <= 1'b0;
      end else begin
        sync1[i] <= pins_in[i];
        sync2[i] <= sync1[i];
        sync3[i] <= sync2[i];
        if (sync2[i] == sync3[i]) begin
          pin_q[i] <= sync3[i];
        end
        pin_d[i] <= pin_q[i];
      end
    end
  end

  assign stop_pin   = pin_q[`STTL_PIN_STOP];
  assign lim_pos    = pin_q[`STTL_PIN_LIM_POS];
  assign lim_neg    = pin_q[`STTL_PIN_LIM_NEG];
  assign lim_any    = lim_pos | lim_neg;
  assign pls_up     = pin_q[`STTL_PIN_PLS_UP] & ~pin_d[`STTL_PIN_PLS_UP];
  assign pls_dn     = pin_q[`STTL_PIN_PLS_DN] & ~pin_d[`STTL_PIN_PLS_DN];
  assign tq_mode    = (mode_sel == sttl_pkg::STTL_MODE_TORQUE);
  assign pulse_mode = (mode_sel == sttl_pkg::STTL_MODE_PULSE);
  assign stopping   = stop_pin | (lim_pos & lim_neg);

  // ---------------------------------------------------------------
  // Servo loop tick and disable timer
  // ---------------------------------------------------------------
  // Ramps step once per servo period
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (tick_cnt == 16'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
      tick     <= 1'b0;
    end
  end

  // Counts disabled time; saturates so a long disable stays cleared
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      dis_cnt <= '0;
    end else if (pin_q[`STTL_PIN_ENABLE]) begin
      dis_cnt <= '0;
    end else if (dis_cnt != 20'(DIS_CYCLES)) begin
      dis_cnt <= dis_cnt + 20'h00001;
    end
  end
  assign dis_clear = (dis_cnt == 20'(DIS_CYCLES));

  // ---------------------------------------------------------------
  // Loop selection
  // ---------------------------------------------------------------
  // torque-only loops; stop forces velocity loop
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pos_loop_en    <= 1'b0;
      vel_loop_en    <= 1'b0;
      torque_loop_en <= 1'b0;
      stop_active    <= 1'b0;
    end else begin
      pos_loop_en    <= pulse_mode & ~stopping;
      vel_loop_en    <= ~tq_mode | stopping;
      torque_loop_en <= 1'b1;
      stop_active    <= stopping;
    end
  end

  // ---------------------------------------------------------------
  // Velocity ramp and limits
  // ---------------------------------------------------------------
  // 112.5 percent speed clamp
  assign vmax = {4'h0, motor_max_speed}
              + {7'h00, motor_max_speed[19:`STTL_VEL_SHIFT]};

  always_comb begin
    if (velocity_cmd_in > $signed(vmax)) begin
      cmd_c = $signed(vmax);
    end else if (velocity_cmd_in < -$signed(vmax)) begin
      cmd_c = -$signed(vmax);
    end else begin
      cmd_c = velocity_cmd_in;
    end
    stepped  = toward_zero(vel_ref, limit_decel_step);
    next_vel = cmd_c;
    if (stopping) begin
      next_vel = toward_zero(vel_ref, stop_decel_step);
    end else if (tq_mode) begin
      next_vel = '0;
    end else if (cmd_c > 24'sh000000 && lim_pos) begin
      next_vel = (cmd_c < stepped) ? cmd_c : stepped;
    end else if (cmd_c < 24'sh000000 && lim_neg) begin
      next_vel = (cmd_c > stepped) ? cmd_c : stepped;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      vel_ref <= '0;
    end else if (tick) begin
      vel_ref <= next_vel;
    end
  end

  // ---------------------------------------------------------------
  // Travel-limit fault and indication
  // ---------------------------------------------------------------
  // log pulse on assertion; indication clears off the switch
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      limit_fault    <= 1'b0;
      limit_indicate <= 1'b0;
    end else begin
      limit_fault    <= (lim_pos & ~pin_d[`STTL_PIN_LIM_POS])
                      | (lim_neg & ~pin_d[`STTL_PIN_LIM_NEG]);
      limit_indicate <= lim_any;
    end
  end

  // ---------------------------------------------------------------
  // Pulse storage
  // ---------------------------------------------------------------
  // clearing conditions
  assign clear_store = stopping | dis_clear;

  // store pulses at limit, saturating at signed 32 bits
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      stored_pulses <= '0;
    end else if (clear_store) begin
      stored_pulses <= '0;
    end else if (pulse_mode && pls_up && !pls_dn) begin
      if (stored_pulses < 0 || lim_pos || stored_pulses > 0) begin
        if (stored_pulses != STORE_MAX) begin
          stored_pulses <= stored_pulses + 32'sd1;
        end
      end
    end else if (pulse_mode && pls_dn && !pls_up) begin
      if (stored_pulses > 0 || lim_neg || stored_pulses < 0) begin
        if (stored_pulses != STORE_MIN) begin
          stored_pulses <= stored_pulses - 32'sd1;
        end
      end
    end
  end

  // pulses pass only with nothing stored
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      position_cmd <= '0;
    end else if (pulse_mode && !clear_store && stored_pulses == 0) begin
      if (pls_up && !pls_dn && !lim_pos) begin
        position_cmd <= position_cmd + 32'sd1;
      end else if (pls_dn && !pls_up && !lim_neg) begin
        position_cmd <= position_cmd - 32'sd1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Torque path
  // ---------------------------------------------------------------
  sttl_torque_scale u_scale (
    .scale       (scale),
    .caps        (caps),
    .cap_prog_en (cap_always_on | cap_enable_in),
    .torque_cmd  (scaled_tq),
    .total_cap   (total_cap)
  );

  // limits still judged in torque-only mode
  always_comb begin
    sel_tq = (tq_mode && !stopping) ? scaled_tq : loop_torque_demand;
    tq_blocked = tq_mode && !stopping &&
                 ((sel_tq > 16'sh0000 && lim_pos) ||
                  (sel_tq < 16'sh0000 && lim_neg));
    if (tq_blocked) begin
      next_act = '0;
    end else if (sel_tq > $signed({1'b0, total_cap})) begin
      next_act = $signed({1'b0, total_cap});
    end else if (sel_tq < -$signed({1'b0, total_cap})) begin
      next_act = -$signed({1'b0, total_cap});
    end else begin
      next_act = sel_tq;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      torque_req          <= '0;
      torque_act          <= '0;
      torque_limit_active <= 1'b0;
    end else begin
      torque_req          <= sel_tq;
      torque_act          <= next_act;
      torque_limit_active <= mag16(next_act) < mag16(sel_tq);
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_stop_vel_loop: assert property (
    stopping |=> vel_loop_en && stop_active)
    else $error("stop did not force velocity loop");
  a_torque_loops: assert property (
    tq_mode && !stopping |=> !vel_loop_en && !pos_loop_en && torque_loop_en)
    else $error("torque mode left outer loops on");
  a_stop_release: assert property (
    $fell(stopping) && tq_mode ##1 tq_mode |-> !vel_loop_en)
    else $error("prior mode not restored after stop");
  a_stop_ramp: assert property (
    tick && stopping && vel_ref > $signed({1'b0, stop_decel_step})
    |=> vel_ref == $past(vel_ref) - $signed({1'b0, $past(stop_decel_step)}))
    else $error("stop ramp step wrong");
  a_limit_hold: assert property (
    tick && !stopping && !tq_mode && lim_pos && vel_ref == 0 &&
    velocity_cmd_in > 0 |=> vel_ref == 0)
    else $error("moved into positive limit");
  a_limit_away: assert property (
    tick && !stopping && !tq_mode && lim_pos && velocity_cmd_in < 0 &&
    velocity_cmd_in > -$signed(vmax) |=> vel_ref == $past(velocity_cmd_in))
    else $error("motion off limit refused");
  a_limit_fault: assert property (
    $rose(lim_pos) && !lim_neg |=> limit_fault ##1 !limit_fault)
    else $error("limit fault not a single pulse");
  a_both_clear: assert property (
    lim_pos && lim_neg |=> stored_pulses == 0)
    else $error("stored pulses survived both limits");
  a_pulse_store: assert property (
    pulse_mode && lim_pos && pls_up && !pls_dn && !clear_store &&
    stored_pulses >= 0 && stored_pulses != STORE_MAX
    |=> stored_pulses == $past(stored_pulses) + 1 && $stable(position_cmd))
    else $error("pulse at limit not stored");
  a_vel_clamp: assert property (
    $stable(motor_max_speed)[*2] |-> vel_ref <= $signed(vmax))
    else $error("velocity above clamp");
  a_tq_flag: assert property (
    torque_limit_active |-> mag16(torque_act) < mag16(torque_req))
    else $error("limit flag without clamping");

  c_stop_seen:  cover property (stopping ##[1:20] !stopping);
  c_store_fill: cover property (pulse_mode && lim_pos && pls_up);
  c_tq_clamp:   cover property (tq_mode && torque_limit_active);
  c_both_lims:  cover property (lim_pos && lim_neg);

endmodule : sttl_supervisor

// *** src/sttl_defines.svh ***
// Timing counts and pin positions for the stop, travel-limit and
// torque-limit supervisor. Included by the supervisor's design files.
`ifndef STTL_DEFINES_SVH
`define STTL_DEFINES_SVH

// ----------------------------------------------------------------
// Clock and times
// ----------------------------------------------------------------
`define STTL_CLK_MHZ       125
`define STTL_TICK_US       400
`define STTL_DIS_CLR_US    5000
`define STTL_TICK_CYCLES   (`STTL_TICK_US * `STTL_CLK_MHZ)
`define STTL_DIS_CYCLES    (`STTL_DIS_CLR_US * `STTL_CLK_MHZ)

// ----------------------------------------------------------------
// Pin vector positions
// ----------------------------------------------------------------
`define STTL_PIN_COUNT     6
`define STTL_PIN_STOP      0
`define STTL_PIN_LIM_POS   1
`define STTL_PIN_LIM_NEG   2
`define STTL_PIN_PLS_UP    3
`define STTL_PIN_PLS_DN    4
`define STTL_PIN_ENABLE    5

// ----------------------------------------------------------------
// Scaling figures
// ----------------------------------------------------------------
`define STTL_FOLD_NUM      4
`define STTL_FOLD_DEN      5
`define STTL_VEL_SHIFT     3
`define STTL_TQ_MAX        32767
`define STTL_TQ_MIN        (-32768)

`endif

// *** src/sttl_pkg.sv ***
// Types shared by the supervisor and its torque scaling stage.
// Assumes nothing beyond a SystemVerilog compiler.
package sttl_pkg;

  // Operating modes chosen by the host
  typedef enum logic [1:0] {
    STTL_MODE_TORQUE,
    STTL_MODE_VELOCITY,
    STTL_MODE_PULSE
  } sttl_mode_t;

  // Analog torque scaling inputs
  typedef struct packed {
    logic signed [15:0] analog_in_value;
    logic signed [15:0] input_zero_offset;
    logic signed [15:0] full_scale_torque;
    logic signed [15:0] input_full_scale;
  } sttl_scale_t;

  // Torque caps, magnitudes; foldback fields hold ratings
  typedef struct packed {
    logic [14:0] peak_motor_torque;
    logic [14:0] peak_drive_torque;
    logic [14:0] rms_foldback_rating;
    logic [14:0] stall_foldback_rating;
    logic [14:0] programmable_torque_cap;
  } sttl_caps_t;

endpackage : sttl_pkg

// *** src/sttl_torque_scale.sv ***
// Analog torque command scaling and total torque cap selection.
// Purely combinational; the supervisor registers the results.
`include "sttl_defines.svh"

module sttl_torque_scale (
  // Inputs
  input  wire sttl_pkg::sttl_scale_t scale,
  input  wire sttl_pkg::sttl_caps_t  caps,
  input  wire logic                  cap_prog_en,
  // Results
  output logic signed [15:0]         torque_cmd,
  output logic        [14:0]         total_cap
);

  logic signed [16:0] diff;
  logic signed [32:0] prod;
  logic signed [32:0] quot;
  logic        [16:0] rms_cap;
  logic        [16:0] stall_cap;
  logic        [14:0] cap_a;
  logic        [14:0] cap_b;

  // ---------------------------------------------------------------
  // Scaling
  // ---------------------------------------------------------------
  // offset, full scale
  always_comb begin
    diff = 17'(scale.analog_in_value) - 17'(scale.input_zero_offset);
    prod = 33'(diff) * 33'(scale.full_scale_torque);
    // Zero full scale would divide by zero; command nothing instead
    if (scale.input_full_scale == 16'sh0000) begin
      quot = '0;
    end else begin
      quot = prod / 33'(scale.input_full_scale);
    end
    if (quot > 33'sd`STTL_TQ_MAX) begin
      torque_cmd = 16'sh7fff;
    end else if (quot < 33'(`STTL_TQ_MIN)) begin
      torque_cmd = 16'sh8000;
    end else begin
      torque_cmd = quot[15:0];
    end
  end

  // ---------------------------------------------------------------
  // Cap selection
  // ---------------------------------------------------------------
  // lowest of caps
  always_comb begin
    rms_cap   = (17'(caps.rms_foldback_rating) * 17'(`STTL_FOLD_NUM))
                / 17'(`STTL_FOLD_DEN);
    stall_cap = (17'(caps.stall_foldback_rating) * 17'(`STTL_FOLD_NUM))
                / 17'(`STTL_FOLD_DEN);
    cap_a = (caps.peak_motor_torque < caps.peak_drive_torque) ?
            caps.peak_motor_torque : caps.peak_drive_torque;
    cap_b = (rms_cap[14:0] < stall_cap[14:0]) ?
            rms_cap[14:0] : stall_cap[14:0];
    total_cap = (cap_a < cap_b) ? cap_a : cap_b;
    if (cap_prog_en && caps.programmable_torque_cap < total_cap) begin
      total_cap = caps.programmable_torque_cap;
    end
  end

endmodule : sttl_torque_scale

// *** bench/sttl_host_model.sv ***
// Host controller model: drives stop, limit, enable and pulse pins.
// Assumes the bench pulses pulse_go for one cycle while not busy.
module sttl_host_model #(
  parameter int HALF = 3
) (
  // Clock
  input  wire logic       clk_sys,
  // Requests from the bench: {enable, minus, plus, stop}
  input  wire logic [3:0] lvl_req,
  input  wire logic [7:0] pulse_num,
  input  wire logic       pulse_neg,
  input  wire logic       pulse_go,
  // Pins and status
  output logic [5:0]      pins_in,
  output logic            pulse_busy
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] left = 8'h00;
  logic [7:0] phase = 8'h00;
  logic       level = 1'b0;
  logic       dir_neg = 1'b0;

  // ----------------
  // Pulse train
  // ----------------
  // whole pulses, one direction
  // Each half lasts HALF cycles so a synchroniser cannot miss it
  always_ff @(posedge clk_sys) begin
    if (pulse_go && !pulse_busy) begin
      left    <= pulse_num;
      dir_neg <= pulse_neg;
      phase   <= 8'h00;
      level   <= 1'b0;
    end else if (left != 8'h00) begin
      if (phase == 8'(HALF - 1)) begin
        phase <= 8'h00;
        level <= !level;
        if (level) left <= left - 8'h01;
      end else begin
        phase <= phase + 8'h01;
      end
    end
  end

  // Up and down never share a cycle
  assign pulse_busy = (left != 8'h00);
  assign pins_in = {lvl_req[3], level & dir_neg, level & ~dir_neg,
                    lvl_req[2:0]};
endmodule : sttl_host_model

// *** bench/servo_stop_travel_torque_limiter_test.sv ***
// Self-checking bench for the stop, limit and torque supervisor.
// Assumes sttl_host_model drives the pins; short counts keep it brief.
module servo_stop_travel_torque_limiter_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 8;
  localparam int DIS  = 20;
  localparam logic [3:0] EN = 4'b1000;
  localparam logic [3:0] PL = 4'b1010;
  localparam logic [3:0] ML = 4'b1100;
  localparam logic [3:0] BL = 4'b1110;
  localparam logic [3:0] ST = 4'b1001;
  logic                  clk_sys = 1'b0;
  logic                  resetn;
  sttl_pkg::sttl_mode_t  mode_sel;
  sttl_pkg::sttl_scale_t scale;
  sttl_pkg::sttl_caps_t  caps;
  logic                  cap_always_on, cap_enable_in;
  logic signed [23:0]    velocity_cmd_in, vel_ref;
  logic signed [15:0]    loop_torque_demand, torque_req, torque_act;
  logic        [19:0]    motor_max_speed;
  logic        [22:0]    stop_decel_step, limit_decel_step;
  logic        [5:0]     pins_in;
  logic        [3:0]     lvl_req;
  logic        [7:0]     pulse_num;
  logic                  pulse_neg, pulse_go, pulse_busy;
  logic                  pos_loop_en, vel_loop_en, torque_loop_en;
  logic signed [31:0]    position_cmd, stored_pulses;
  logic                  torque_limit_active, stop_active;
  logic                  limit_fault, limit_indicate;
  int                    n_fail = 0;
  int                    checked = 0;
  int                    n_fault = 0;

  sttl_supervisor #(.TICK_CYCLES(TICK), .DIS_CYCLES(DIS)) i_sttl_supervisor (
    .clk_sys, .resetn, .mode_sel, .scale, .caps, .cap_always_on,
    .cap_enable_in, .velocity_cmd_in, .loop_torque_demand,
    .motor_max_speed, .stop_decel_step, .limit_decel_step, .pins_in,
    .pos_loop_en, .vel_loop_en, .torque_loop_en, .vel_ref, .torque_req,
    .torque_act, .position_cmd, .torque_limit_active, .stop_active,
    .limit_fault, .limit_indicate, .stored_pulses);
  sttl_host_model #(.HALF(3)) i_sttl_host_model (
    .clk_sys, .lvl_req, .pulse_num, .pulse_neg, .pulse_go, .pins_in,
    .pulse_busy);

  // ----------------
  // Clock and helpers
  // ----------------
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (limit_fault === 1'b1) n_fault++;

  task automatic check_val(input logic signed [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_bit(input logic got, exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_bit

  task automatic look(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : look

  task automatic pins(input logic [3:0] v);
    @(posedge clk_sys);
    lvl_req <= v;
  endtask : pins

  // Waits one pulse train out, then the synchroniser delay
  task automatic send(input logic [7:0] n, input logic neg);
    int i;
    @(posedge clk_sys);
    pulse_num <= n;
    pulse_neg <= neg;
    pulse_go  <= 1'b1;
    @(posedge clk_sys);
    pulse_go  <= 1'b0;
    // Busy shows only once the model has taken the request
    @(negedge clk_sys);
    for (i = 0; i < 400 && pulse_busy !== 1'b0; i++) @(posedge clk_sys);
    look(6);
  endtask : send

  // Velocity only moves on a tick, so wait for the next change
  task automatic next_vref(input logic signed [23:0] exp);
    logic signed [23:0] old;
    int i;
    // Skip a change launched on the calling edge itself
    @(negedge clk_sys);
    old = vel_ref;
    for (i = 0; i < 4 * TICK && vel_ref === old; i++) @(negedge clk_sys);
    check_val(vel_ref, exp);
  endtask : next_vref

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  // ----------------
  // Scenarios
  // ----------------
  task automatic t_torque();
    look(2);
    check_bit(pos_loop_en, 1'b0);
    check_bit(torque_loop_en, 1'b1);
    check_val(torque_req, 32'sh960);
    check_bit(torque_limit_active, 1'b0);
    @(posedge clk_sys);
    cap_enable_in <= 1'b1;
    look(1);
    check_val(torque_act, 32'sh3e8);
    check_bit(torque_limit_active, 1'b1);
    @(posedge clk_sys);
    cap_enable_in <= 1'b0;
    cap_always_on <= 1'b1;
    caps.rms_foldback_rating <= 15'h3e8;
    look(1);
    check_val(torque_act, 32'sh320);
    @(posedge clk_sys);
    caps.stall_foldback_rating <= 15'h1f4;
    scale.analog_in_value <= -16'sh258;
    look(1);
    check_val(torque_act, -32'sh190);
    @(posedge clk_sys);
    scale.analog_in_value <= 16'sh3e8;
    pins(PL);
    look(6);
    check_val(torque_act, 32'sh0);
    check_bit(torque_limit_active, 1'b1);
    pins(EN);
  endtask : t_torque

  task automatic t_stop();
    @(posedge clk_sys);
    mode_sel <= sttl_pkg::STTL_MODE_VELOCITY;
    velocity_cmd_in <= 24'sh7d0;
    next_vref(24'sh384);
    @(posedge clk_sys);
    velocity_cmd_in <= -24'sh7d0;
    next_vref(-24'sh384);
    @(posedge clk_sys);
    velocity_cmd_in <= 24'sh64;
    next_vref(24'sh64);
    pins(ST);
    next_vref(24'sh46);
    next_vref(24'sh28);
    next_vref(24'sha);
    next_vref(24'sh0);
    check_bit(stop_active, 1'b1);
    check_bit(pos_loop_en, 1'b0);
    pins(EN);
    next_vref(24'sh64);
    @(posedge clk_sys);
    mode_sel <= sttl_pkg::STTL_MODE_TORQUE;
    pins(ST);
    look(6);
    check_bit(vel_loop_en, 1'b1);
    check_val(torque_req, 32'sh1f4);
    pins(EN);
    look(6);
    check_bit(vel_loop_en, 1'b0);
    check_val(torque_req, 32'sh960);
  endtask : t_stop

  task automatic t_limit();
    int n0;
    n0 = n_fault;
    @(posedge clk_sys);
    mode_sel <= sttl_pkg::STTL_MODE_VELOCITY;
    velocity_cmd_in <= 24'sh190;
    next_vref(24'sh190);
    pins(PL);
    next_vref(24'sh12c);
    @(posedge clk_sys);
    velocity_cmd_in <= 24'sh32;
    next_vref(24'sh32);
    next_vref(24'sh0);
    // Positive command at the limit must keep the axis held
    next_vref(24'sh0);
    check_val(n_fault - n0, 32'sh1);
    check_bit(limit_indicate, 1'b1);
    @(posedge clk_sys);
    velocity_cmd_in <= -24'sh190;
    next_vref(-24'sh190);
    pins(EN);
    look(6);
    check_bit(limit_indicate, 1'b0);
    pins(ML);
    next_vref(-24'sh12c);
    @(posedge clk_sys);
    velocity_cmd_in <= 24'sh190;
    next_vref(24'sh190);
  endtask : t_limit

  task automatic t_both();
    pins(BL);
    next_vref(24'sh172);
    check_bit(stop_active, 1'b1);
    @(posedge clk_sys);
    velocity_cmd_in <= -24'sh190;
    look(20 * TICK);
    check_val(vel_ref, 32'sh0);
    pins(PL);
    next_vref(-24'sh190);
    check_bit(stop_active, 1'b0);
  endtask : t_both

  task automatic t_pulse();
    @(posedge clk_sys);
    mode_sel <= sttl_pkg::STTL_MODE_PULSE;
    pins(EN);
    send(8'h05, 1'b0);
    check_val(position_cmd, 32'sh5);
    pins(PL);
    send(8'h03, 1'b0);
    check_val(stored_pulses, 32'sh3);
    check_val(position_cmd, 32'sh5);
    send(8'h02, 1'b1);
    check_val(stored_pulses, 32'sh1);
    pins(ST | PL);
    look(6);
    check_val(stored_pulses, 32'sh0);
    pins(PL);
    send(8'h02, 1'b0);
    pins(BL);
    look(6);
    check_val(stored_pulses, 32'sh0);
    pins(EN);
    send(8'h01, 1'b1);
    check_val(position_cmd, 32'sh4);
    pins(PL);
    send(8'h02, 1'b0);
    pins(4'b0010);
    look(DIS + 10);
    check_val(stored_pulses, 32'sh0);
  endtask : t_pulse

  // ----------------
  // Main sequence and watchdog
  // ----------------
  initial begin
    resetn = 1'b0;
    mode_sel = sttl_pkg::STTL_MODE_TORQUE;
    scale = '{16'sh3e8, 16'sh0c8, 16'shbb8, 16'sh3e8};
    caps = '{15'h4e20, 15'h4e20, 15'h4e20, 15'h4e20, 15'h3e8};
    cap_always_on = 1'b0;
    cap_enable_in = 1'b0;
    velocity_cmd_in = 24'sh0;
    loop_torque_demand = 16'sh1f4;
    motor_max_speed = 20'h320;
    stop_decel_step = 23'h1e;
    limit_decel_step = 23'h64;
    lvl_req = EN;
    pulse_num = 8'h00;
    pulse_neg = 1'b0;
    pulse_go = 1'b0;
    look(2);
    check_val(position_cmd, 32'sh0);
    check_bit(stop_active, 1'b0);
    @(posedge clk_sys);
    resetn <= 1'b1;
    t_torque();
    t_stop();
    t_limit();
    t_both();
    t_pulse();
    stop_test();
  end

  initial begin
    // About five times the expected run length
    repeat (3000) @(posedge clk_sys);
    n_fail++;
    stop_test();
  end
endmodule : servo_stop_travel_torque_limiter_test
